/* File: src/fcs_defines.vh */
// constants for the flash card program and erase host sequencer
`ifndef FCS_DEFINES_VH
`define FCS_DEFINES_VH
`define FCS_CMD_RESET     16'hf0f0
`define FCS_CMD_UNLOCK1   16'haaaa
`define FCS_CMD_UNLOCK2   16'h5555
`define FCS_CMD_ERASE_SET 16'h8080
`define FCS_CMD_PROGRAM   16'ha0a0
`define FCS_CMD_SECTOR    16'h3030
`define FCS_ADDR_UNLOCK1  26'h0005555
`define FCS_ADDR_UNLOCK2  26'h0005554
`define FCS_POLL_BIT      7
`define FCS_CLK_NS        40
`define FCS_SETUP_NS      120
`define FCS_SETUP_CYC     ((`FCS_SETUP_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_WINDOW_US     50
`define FCS_WINDOW_CYC    ((`FCS_WINDOW_US * 1000 + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_OP_PROGRAM    2'h1
`define FCS_OP_ERASE      2'h2
`define FCS_OP_RESET      2'h3
`endif

/* File: src/fcs_strobe.v */
// one write or read bus cycle with strobe timing
`include "fcs_defines.vh"
module fcs_strobe (
	input  wire        core_clk,
	input  wire        rst,
	input  wire        ce,
	input  wire        go,
	input  wire        is_read,
	output reg         we_n,
	output reg         oe_n,
	output reg         done
);
	localparam [1:0] S_IDLE = 2'h0;
	localparam [1:0] S_LOW  = 2'h1;
	localparam [1:0] S_HIGH = 2'h2;
	localparam [31:0] SETUP_LAST = `FCS_SETUP_CYC - 1;
	reg [1:0] state_reg;
	reg [3:0] cnt_reg;
	always @(posedge core_clk) begin
		if (rst) begin
			state_reg <= S_IDLE;
			cnt_reg   <= 4'h0;
			we_n      <= 1'b1;
			oe_n      <= 1'b1;
			done      <= 1'b0;
		end else if (ce) begin
			done <= 1'b0;
			case (state_reg)
				S_IDLE: begin
					if (go) begin
						state_reg <= S_LOW;
						cnt_reg   <= 4'h0;
						we_n      <= is_read;
						oe_n      <= ~is_read;
					end
				end
				S_LOW: begin
					cnt_reg <= cnt_reg + 4'h1;
					if (cnt_reg == SETUP_LAST[3:0]) begin
						state_reg <= S_HIGH;
						cnt_reg   <= 4'h0;
						we_n      <= 1'b1;
						oe_n      <= 1'b1;
					end
				end
				S_HIGH: begin
					cnt_reg <= cnt_reg + 4'h1;
					if (cnt_reg == SETUP_LAST[3:0]) begin
						state_reg <= S_IDLE;
						done      <= 1'b1;
					end
				end
				default: state_reg <= S_IDLE;
			endcase
		end
	end
endmodule

/* File: src/fcs_host.v */
// host sequencer issuing program, sector erase and reset command strings
`include "fcs_defines.vh"
module fcs_host (
	input  wire        core_clk,
	input  wire        rst,
	input  wire        clk_en,
	input  wire        cmd_valid,
	input  wire [1:0]  cmd_op,
	input  wire [25:0] cmd_addr,
	input  wire [15:0] cmd_data,
	input  wire        extra_valid,
	input  wire [25:0] extra_addr,
	input  wire [15:0] flash_dq_in,
	input  wire        ready_busy_in,
	output reg         cmd_ready,
	output reg         extra_ready,
	output reg         op_done,
	output reg         op_aborted,
	output reg  [25:0] flash_addr,
	output reg  [15:0] flash_dq_out,
	output reg         flash_dq_oe,
	output reg         flash_we_n,
	output reg         flash_oe_n,
	output reg         busy
);
	localparam [2:0] H_IDLE  = 3'h0;
	localparam [2:0] H_WRITE = 3'h1;
	localparam [2:0] H_WAITW = 3'h2;
	localparam [2:0] H_QUEUE = 3'h3;
	localparam [2:0] H_POLL  = 3'h4;
	localparam [2:0] H_WAITR = 3'h5;
	localparam [31:0] WIN_CYC = `FCS_WINDOW_CYC;
	reg  [2:0]  state_reg;
	reg  [2:0]  step_reg;
	reg  [2:0]  nsteps_reg;
	reg  [1:0]  op_reg;
	reg  [25:0] tgt_addr_reg;
	reg  [15:0] tgt_data_reg;
	reg  [15:0] rd_data_reg;
	reg  [10:0] win_reg;
	reg         go_reg;
	reg         rd_reg;
	wire        st_we_n;
	wire        st_oe_n;
	wire        st_done;
	reg  [25:0] w_addr;
	reg  [15:0] w_data;
	fcs_strobe u_strobe (
		.core_clk (core_clk),
		.rst      (rst),
		.ce       (clk_en),
		.go       (go_reg),
		.is_read  (rd_reg),
		.we_n     (st_we_n),
		.oe_n     (st_oe_n),
		.done     (st_done)
	);
	// address and data of each command step
	always @* begin
		w_addr = `FCS_ADDR_UNLOCK1;
		w_data = `FCS_CMD_UNLOCK1;
		if (op_reg == `FCS_OP_RESET) begin
			w_data = `FCS_CMD_RESET;
		end else if (op_reg == `FCS_OP_PROGRAM) begin
			case (step_reg)
				3'h1: w_data = `FCS_CMD_UNLOCK2;
				3'h2: w_data = `FCS_CMD_PROGRAM;
				3'h3: begin
					w_addr = tgt_addr_reg;
					w_data = tgt_data_reg;
				end
				default: w_data = `FCS_CMD_UNLOCK1;
			endcase
		end else begin
			case (step_reg)
				3'h1: w_data = `FCS_CMD_UNLOCK2;
				3'h2: w_data = `FCS_CMD_ERASE_SET;
				3'h4: begin
					w_addr = `FCS_ADDR_UNLOCK2;
					w_data = `FCS_CMD_UNLOCK2;
				end
				3'h5: begin
					w_addr = tgt_addr_reg;
					w_data = `FCS_CMD_SECTOR;
				end
				default: w_data = `FCS_CMD_UNLOCK1;
			endcase
		end
	end
	always @(posedge core_clk) begin
		if (rst) begin
			state_reg    <= H_IDLE;
			step_reg     <= 3'h0;
			nsteps_reg   <= 3'h0;
			op_reg       <= 2'h0;
			tgt_addr_reg <= 26'h0;
			tgt_data_reg <= 16'h0;
			rd_data_reg  <= 16'h0;
			win_reg      <= 11'h0;
			go_reg       <= 1'b0;
			rd_reg       <= 1'b0;
			cmd_ready    <= 1'b0;
			extra_ready  <= 1'b0;
			op_done      <= 1'b0;
			op_aborted   <= 1'b0;
			flash_addr   <= 26'h0;
			flash_dq_out <= 16'h0;
			flash_dq_oe  <= 1'b0;
			flash_we_n   <= 1'b1;
			flash_oe_n   <= 1'b1;
			busy         <= 1'b0;
		end else if (clk_en) begin
			go_reg      <= 1'b0;
			op_done     <= 1'b0;
			op_aborted  <= 1'b0;
			extra_ready <= 1'b0;
			flash_we_n  <= st_we_n;
			flash_oe_n  <= st_oe_n;
			// sample card data while its output is enabled
			if (!flash_oe_n)
				rd_data_reg <= flash_dq_in;
			case (state_reg)
				H_IDLE: begin
					flash_dq_oe <= 1'b0;
					// hold off while device reports busy
					cmd_ready <= ready_busy_in;
					if (cmd_valid && cmd_ready && ready_busy_in) begin
						cmd_ready    <= 1'b0;
						busy         <= 1'b1;
						op_reg       <= cmd_op;
						tgt_addr_reg <= cmd_addr;
						tgt_data_reg <= cmd_data;
						step_reg     <= 3'h0;
						nsteps_reg   <= (cmd_op == `FCS_OP_RESET) ? 3'h1 :
							(cmd_op == `FCS_OP_PROGRAM) ? 3'h4 : 3'h6;
						state_reg    <= H_WRITE;
					end
				end
				H_WRITE: begin
					// address and data stable across the strobe
					flash_addr   <= w_addr;
					flash_dq_out <= w_data;
					flash_dq_oe  <= 1'b1;
					go_reg       <= 1'b1;
					rd_reg       <= 1'b0;
					state_reg    <= H_WAITW;
				end
				H_WAITW: begin
					if (st_done) begin
						if (step_reg == nsteps_reg - 3'h1) begin
							flash_dq_oe <= 1'b0;
							if (op_reg == `FCS_OP_RESET) begin
								op_done   <= 1'b1;
								busy      <= 1'b0;
								state_reg <= H_IDLE;
							end else if (op_reg == `FCS_OP_ERASE) begin
								// window counted from last sector write
								win_reg   <= WIN_CYC[10:0];
								state_reg <= H_QUEUE;
							end else begin
								state_reg <= H_POLL;
							end
						end else begin
							step_reg  <= step_reg + 3'h1;
							state_reg <= H_WRITE;
						end
					end
				end
				H_QUEUE: begin
					flash_dq_oe <= 1'b0;
					// queue further sectors inside the window
					if (extra_valid && win_reg > 11'h1) begin
						extra_ready <= 1'b1;
						step_reg    <= 3'h5;
						nsteps_reg  <= 3'h6;
						tgt_addr_reg <= extra_addr;
						state_reg   <= H_WRITE;
					end else if (win_reg == 11'h0) begin
						state_reg <= H_POLL;
					end else begin
						win_reg <= win_reg - 11'h1;
					end
				end
				H_POLL: begin
					flash_addr  <= tgt_addr_reg;
					flash_dq_oe <= 1'b0;
					go_reg      <= 1'b1;
					rd_reg      <= 1'b1;
					state_reg   <= H_WAITR;
				end
				H_WAITR: begin
					if (st_done) begin
						if ((op_reg == `FCS_OP_ERASE && rd_data_reg[`FCS_POLL_BIT]) ||
							(op_reg == `FCS_OP_PROGRAM &&
							rd_data_reg[`FCS_POLL_BIT] == tgt_data_reg[`FCS_POLL_BIT])) begin
							op_done   <= 1'b1;
							busy      <= 1'b0;
							state_reg <= H_IDLE;
						end else begin
							state_reg <= H_POLL;
						end
					end
				end
				default: state_reg <= H_IDLE;
			endcase
		end
	end
endmodule

/* File: bench/fcs_host_props.sv */
// port assertions for the host sequencer
module fcs_host_props (
	input logic        core_clk,
	input logic        rst,
	input logic        cmd_valid,
	input logic        cmd_ready,
	input logic        extra_valid,
	input logic        extra_ready,
	input logic        ready_busy_in,
	input logic        op_done,
	input logic        busy,
	input logic [25:0] flash_addr,
	input logic [15:0] flash_dq_out,
	input logic        flash_dq_oe,
	input logic        flash_we_n,
	input logic        flash_oe_n
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence s_low3;
		!flash_we_n[*3] ##1 flash_we_n;
	endsequence
	sequence s_held;
		($stable(flash_addr) && $stable(flash_dq_out) && flash_dq_oe)[*4];
	endsequence
	a_we_low: assert property ($fell(flash_we_n) |-> s_low3)
		else $error("write strobe low time wrong");
	a_we_gap: assert property ($rose(flash_we_n) |-> flash_we_n[*3])
		else $error("write strobe high time wrong");
	a_addr_held: assert property ($fell(flash_we_n) |-> s_held)
		else $error("address or data moved in write");
	a_poll_read: assert property (!flash_oe_n |-> flash_we_n && !flash_dq_oe)
		else $error("read overlaps write or drive");
	a_take_ready: assert property (cmd_valid && cmd_ready |-> ready_busy_in)
		else $error("request taken while card busy");
	a_take_busy: assert property (cmd_valid && cmd_ready |=> busy && !cmd_ready)
		else $error("taken request did not start");
	a_done_pulse: assert property (op_done |=> !op_done)
		else $error("done longer than one cycle");
	a_extra_win: assert property (extra_ready |-> $past(extra_valid) && busy)
		else $error("extra sector taken without request");
	a_rst_quiet: assert property (disable iff (1'b0) rst |=> flash_we_n && flash_oe_n && !busy && !cmd_ready)
		else $error("outputs not quiet after reset");
endmodule
bind fcs_host fcs_host_props u_props (.core_clk, .rst, .cmd_valid, .cmd_ready, .extra_valid, .extra_ready,
	.ready_busy_in, .op_done, .busy, .flash_addr, .flash_dq_out, .flash_dq_oe, .flash_we_n, .flash_oe_n);

/* File: bench/fcs_card_model.sv */
// behavioural flash card: command decode, ready busy and poll bit
module fcs_card_model (
	input  wire logic [25:0] addr,
	input  wire logic [15:0] din,
	input  wire logic        we_n,
	input  wire logic        oe_n,
	output logic      [15:0] dq,
	output logic             ready_busy_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [25:0] la, pa;
	logic [15:0] pd, c3, last, rd;
	logic        prog, win, ers;
	int          n, writes, gen;
	bit          sel [2048];
	function automatic bit has(logic [25:0] a);
		return sel[a[25:15]];
	endfunction
	initial begin
		{prog, win, ers, pa, pd, c3, last} = '0;
		{n, writes, gen} = '0;
		ready_busy_out = 1'b1;
	end
	task automatic timer(int g);
		#50000;
		if (g != gen) return;
		win = 0;
		ers = 1;
		#20000;
		if (g == gen) begin
			ers = 0;
			ready_busy_out = 1'b1;
		end
	endtask
	// address on fall, data on rise
	always @(negedge we_n) begin
		la = addr;
		@(posedge we_n);
		writes++;
		if (prog)
			n = 0;
		else if (din == 16'hf0f0) begin
			{n, win, ers} = '0;
			gen++;
			ready_busy_out = 1'b1;
		end
		else if (win && din == 16'h3030) begin
			sel[la[25:15]] = 1'b1;
			gen++;
			fork timer(gen); join_none
		end
		else if (win) begin
			{n, win} = '0;
			gen++;
			ready_busy_out = 1'b1;
		end
		else if (!ers) begin
			n++;
			if (n == 3) c3 = din;
			if (n == 4 && c3 == 16'ha0a0) begin
				{n, pa, pd, prog, ready_busy_out} = {32'h0, la, din, 2'b10};
				fork begin #2000; prog = 0; ready_busy_out = 1'b1; end join_none
			end
			if (n == 6 && c3 == 16'h8080 && din == 16'h3030) begin
				foreach (sel[i]) sel[i] = 1'b0;
				sel[la[25:15]] = 1'b1;
				{win, ready_busy_out} = 2'b10;
				gen++;
				fork timer(gen); join_none
			end
			if (n >= 6) n = 0;
		end
	end
	// poll bit, then data at that address only
	always @* begin
		if (prog) rd = ~pd & 16'h0080;
		else if (win || ers) rd = 16'h0000;
		else if (addr == pa) rd = pd;
		else rd = has(addr) ? 16'hffff : 16'h5a5a;
		dq = oe_n ? ~last : rd;
	end
	always @(posedge oe_n) last = rd;
endmodule

/* File: bench/fcs_host_tb.sv */
// bench for the host sequencer against the card model
module fcs_host_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        core_clk, rst, cmd_valid, extra_valid, rb, cmd_ready, extra_ready, op_done, dq_oe, we_n, oe_n, busy;
	logic        aborted;
	logic [1:0]  cmd_op;
	logic [25:0] cmd_addr, extra_addr, addr;
	logic [15:0] cmd_data, dq_in, dq_out;
	int          errors, checks_done, w0, k;
	fcs_host DUT (.core_clk, .rst, .clk_en(1'b1), .cmd_valid, .cmd_op, .cmd_addr, .cmd_data, .extra_valid,
		.extra_addr, .flash_dq_in(dq_in), .ready_busy_in(rb), .cmd_ready, .extra_ready, .op_done, .op_aborted(aborted),
		.flash_addr(addr), .flash_dq_out(dq_out), .flash_dq_oe(dq_oe), .flash_we_n(we_n), .flash_oe_n(oe_n), .busy);
	fcs_card_model card (.addr, .din(dq_out), .we_n, .oe_n, .dq(dq_in), .ready_busy_out(rb));
	task automatic check(string what, logic [31:0] exp, logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tick;
		@(posedge core_clk);
		#2;
	endtask
	task automatic run(logic [1:0] op, logic [25:0] a, logic [15:0] d);
		w0 = card.writes;
		{cmd_op, cmd_addr, cmd_data, cmd_valid} = {op, a, d, 1'b1};
		for (k = 0; k < 99 && cmd_ready !== 1'b1; k++) tick;
		tick;
		cmd_valid = 0;
		for (k = 0; k < 4000 && op_done !== 1'b1; k++) tick;
		check("op_done", 1, op_done);
		check("op_aborted", 0, aborted);
	endtask
	task automatic t_program(logic [25:0] a, logic [15:0] d);
		run(2'h1, a, d);
		check("writes", 4, card.writes - w0);
		check("address", a, card.pa);
		check("data", d, card.pd);
		check("ready pin", 1, rb);
		$display("program test done");
	endtask
	task automatic t_erase(logic [25:0] a, logic [25:0] b);
		fork
			run(2'h2, a, 16'h0);
			begin
				for (int i = 0; i < 999 && card.win !== 1'b1; i++) tick;
				check("busy pin", 0, rb);
				{extra_addr, extra_valid} = {b, 1'b1};
				for (int i = 0; i < 999 && extra_ready !== 1'b1; i++) tick;
				extra_valid = 0;
			end
		join
		check("writes", 7, card.writes - w0);
		check("sector", 1, card.has(a));
		check("extra", 1, card.has(b));
		$display("erase test done");
	endtask
	task automatic t_reset;
		run(2'h3, 26'h0, 16'h0);
		check("writes", 1, card.writes - w0);
		$display("reset test done");
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		core_clk = 0;
		forever #20 core_clk = ~core_clk;
	end
	initial begin
		#800000;
		errors++;
		tally_and_finish;
	end
	initial begin
		{cmd_valid, extra_valid, cmd_op, cmd_addr, cmd_data, extra_addr} = '0;
		rst = 1;
		repeat (12) @(posedge core_clk);
		#2 rst = 0;
		tick;
		t_program(26'h0012340, 16'h12b4);
		t_program(26'h0012341, 16'hcd87);
		t_erase(26'h0120000, 26'h0038000);
		t_reset;
		tally_and_finish;
	end
endmodule
